// ===== hw/ccint_top.v
`timescale 1ns/10ps
`include "ccint_defines.vh"
// Notes on behaviour
// - interrupt output high after reset
// - card insertion or removal drives interrupt low
// - card supply fault drives interrupt low
// - assertion ignores chip select and chip address
// - insertion cleared by any supply setting; overload only by zero
// - clear needs chip select low and address 0xx or 101
// - host acks insertion by programming nonzero supply; interrupt released
// - extraction asserts interrupt and starts deactivation automatically
// - extraction interrupt released by selected zero supply write
// - extraction deactivation order reset, clock, aux pair, data, supply, 500 ns steps; fault or host zero write cuts supply first
// - card events debounced 50 us; host power-down starts immediately
// - new event while pending keeps interrupt low until valid clear
// - supply out of window stops converter, deactivates, interrupts
module ccint_top #(
    parameter DEBOUNCE_CYC = `CCINT_DEBOUNCE_CYC,
    parameter STEP_CYC = `CCINT_STEP_CYC
) (
    input wire CLK_I,
    input wire RST_I,
    input wire CARD_PRESENCE_IN_I,
    input wire SUPPLY_FAULT_I,
    input wire CS_N_I,
    input wire CMD_STROBE_I,
    input wire [7:0] CMD_BYTE_I,
    output reg INT_N_O,
    output reg [1:0] CARD_SUPPLY_LEVEL_O,
    output reg CONVERTER_EN_O,
    output reg CARD_PRESENT_O,
    output reg PEND_INSERT_O,
    output reg PEND_OVERLOAD_O,
    output reg CARD_RESET_LOW_O,
    output reg CARD_CLOCK_LOW_O,
    output reg AUX_CONTACT_A_LOW_O,
    output reg AUX_CONTACT_B_LOW_O,
    output reg CARD_DATA_LINE_LOW_O,
    output wire DEACT_BUSY_O
);
    localparam DW = 24;

    // address decode used by the clear path
    function addr_match;
        input [2:0] a;
        begin
            addr_match = (a[2] == 1'b0) || (a == `CCINT_ADDR_SEL_B);
        end
    endfunction

    wire [2:0] chip_address_bits = CMD_BYTE_I[`CCINT_ADDR_MSB:`CCINT_ADDR_LSB];
    wire [1:0] supply_setting_bits = CMD_BYTE_I[`CCINT_SUPPLY_MSB:`CCINT_SUPPLY_LSB];
    // only a selected chip with a matching address accepts a write
    wire sel_write = CMD_STROBE_I && !CS_N_I && addr_match(chip_address_bits);
    wire zero_write = sel_write && (supply_setting_bits == 2'b00);

    // debounce: the filtered state follows only after a stable period
    reg [DW-1:0] db_cnt;
    reg presence_filt;
    reg presence_prev;
    wire card_event = presence_filt != presence_prev;
    always @(posedge CLK_I) begin
        if (RST_I) begin
            db_cnt <= {DW{1'b0}};
            presence_filt <= 1'b0;
            presence_prev <= 1'b0;
        end else begin
            presence_prev <= presence_filt;
            if (CARD_PRESENCE_IN_I == presence_filt) begin
                db_cnt <= {DW{1'b0}};
            end else if (db_cnt == DEBOUNCE_CYC[DW-1:0] - 24'h00_0001) begin
                db_cnt <= {DW{1'b0}};
                presence_filt <= CARD_PRESENCE_IN_I;
            end else begin
                db_cnt <= db_cnt + 24'h00_0001;
            end
        end
    end

    wire extract_event = card_event && !presence_filt;
    // supply fault sampled as an edge so a held fault gives one event
    reg fault_prev;
    wire fault_event = SUPPLY_FAULT_I && !fault_prev;

    // pending flags: set always wins over clear; not gated by select
    reg next_pend_insert;
    reg next_pend_overload;
    always @* begin
        next_pend_insert = PEND_INSERT_O;
        next_pend_overload = PEND_OVERLOAD_O;
        if (sel_write) begin
            next_pend_insert = 1'b0;
        end
        if (zero_write) begin
            next_pend_overload = 1'b0;
        end
        if (card_event) begin
            next_pend_insert = 1'b1;
        end
        if (fault_event) begin
            next_pend_overload = 1'b1;
        end
    end

    always @(posedge CLK_I) begin
        if (RST_I) begin
            PEND_INSERT_O <= 1'b0;
            PEND_OVERLOAD_O <= 1'b0;
            INT_N_O <= 1'b1;
            fault_prev <= 1'b0;
            CARD_PRESENT_O <= 1'b0;
        end else begin
            PEND_INSERT_O <= next_pend_insert;
            PEND_OVERLOAD_O <= next_pend_overload;
            INT_N_O <= !(next_pend_insert || next_pend_overload);
            fault_prev <= SUPPLY_FAULT_I;
            CARD_PRESENT_O <= presence_filt;
        end
    end

    // deactivation starts on filtered extraction, fault, or host zero write while the supply is nonzero
    wire host_down = zero_write && (CARD_SUPPLY_LEVEL_O != 2'b00);
    wire seq_start = extract_event || fault_event || host_down;
    wire [4:0] force_low;
    ccint_deact_seq #(
        .STEP_CYC(STEP_CYC)
    ) u_seq (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .start_i(seq_start),
        .force_low_o(force_low),
        .busy_o(DEACT_BUSY_O)
    );

    // supply setting and converter; a fault kills the converter at once
    always @(posedge CLK_I) begin
        if (RST_I) begin
            CARD_SUPPLY_LEVEL_O <= `CCINT_SUPPLY_RST;
            CONVERTER_EN_O <= 1'b0;
        end else if (fault_event) begin
            CONVERTER_EN_O <= 1'b0;
            CARD_SUPPLY_LEVEL_O <= 2'b00;
        end else if (sel_write && supply_setting_bits != 2'b00) begin
            CARD_SUPPLY_LEVEL_O <= supply_setting_bits;
            CONVERTER_EN_O <= 1'b1;
        end else if (force_low[4] || zero_write) begin
            CARD_SUPPLY_LEVEL_O <= 2'b00;
            CONVERTER_EN_O <= 1'b0;
        end
    end

    // card line forcing; released when the host powers the card again with no deactivation running
    always @(posedge CLK_I) begin
        if (RST_I) begin
            CARD_RESET_LOW_O <= 1'b1;
            CARD_CLOCK_LOW_O <= 1'b1;
            AUX_CONTACT_A_LOW_O <= 1'b1;
            AUX_CONTACT_B_LOW_O <= 1'b1;
            CARD_DATA_LINE_LOW_O <= 1'b1;
        end else if (sel_write && supply_setting_bits != 2'b00 && !DEACT_BUSY_O) begin
            CARD_RESET_LOW_O <= 1'b0;
            CARD_CLOCK_LOW_O <= 1'b0;
            AUX_CONTACT_A_LOW_O <= 1'b0;
            AUX_CONTACT_B_LOW_O <= 1'b0;
            CARD_DATA_LINE_LOW_O <= 1'b0;
        end else begin
            CARD_RESET_LOW_O <= CARD_RESET_LOW_O | force_low[0];
            CARD_CLOCK_LOW_O <= CARD_CLOCK_LOW_O | force_low[1];
            AUX_CONTACT_A_LOW_O <= AUX_CONTACT_A_LOW_O | force_low[2];
            AUX_CONTACT_B_LOW_O <= AUX_CONTACT_B_LOW_O | force_low[2];
            CARD_DATA_LINE_LOW_O <= CARD_DATA_LINE_LOW_O | force_low[3];
        end
    end
endmodule // ccint_top

// ===== include/ccint_defines.vh
`ifndef CCINT_DEFINES_VH
`define CCINT_DEFINES_VH
// command byte field positions
`define CCINT_ADDR_MSB 7
`define CCINT_ADDR_LSB 5
`define CCINT_SUPPLY_MSB 1
`define CCINT_SUPPLY_LSB 0
// chip address patterns: 0xx selects, 101 selects
`define CCINT_ADDR_SEL_B 3'b101
// timing
`define CCINT_CLK_MHZ 100
`define CCINT_STEP_NS 500
`define CCINT_STEP_CYC ((`CCINT_STEP_NS * `CCINT_CLK_MHZ) / 1000)
`define CCINT_DEBOUNCE_US 50
`define CCINT_DEBOUNCE_CYC (`CCINT_DEBOUNCE_US * `CCINT_CLK_MHZ)
// reset values
`define CCINT_SUPPLY_RST 2'b00
`endif

// ===== hw/ccint_deact_seq.v
`timescale 1ns/10ps
`include "ccint_defines.vh"
// card deactivation sequencer: reset, clock, aux pair, data, supply
module ccint_deact_seq #(
    parameter STEP_CYC = `CCINT_STEP_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire start_i,
    output reg [4:0] force_low_o,
    output wire busy_o
);
    localparam CW = 16;
    reg [CW-1:0] cnt;
    reg [2:0] step;
    assign busy_o = (step != 3'd0) && (step != 3'd6);
    // each step forces one more line, or the aux pair together, low after a fixed spacing
    always @(posedge clk_i) begin
        if (rst_i) begin
            step <= 3'd0;
            cnt <= {CW{1'b0}};
            force_low_o <= 5'b0_0000;
        end else if (start_i && !busy_o) begin
            step <= 3'd1;
            cnt <= {CW{1'b0}};
            force_low_o <= 5'b0_0001;
        end else if (busy_o) begin
            if (cnt == STEP_CYC[CW-1:0] - 16'h0001) begin
                cnt <= {CW{1'b0}};
                step <= step + 3'd1;
                // supply switched off last, after data line
                case (step)
                    3'd1: force_low_o <= 5'b0_0011;
                    3'd2: force_low_o <= 5'b0_0111;
                    3'd3: force_low_o <= 5'b0_1111;
                    3'd4: force_low_o <= 5'b1_1111;
                    default: force_low_o <= force_low_o;
                endcase
            end else begin
                cnt <= cnt + 16'h0001;
            end
        end else if (step == 3'd6) begin
            // drop the force pulses; the top latches each line until the host powers up again,
            // so a stale force here would pull the lines and supply down right after a release
            step <= 3'd0;
            force_low_o <= 5'b0_0000;
        end
    end
endmodule // ccint_deact_seq

// ===== testbench/ccint_top_assertions.sv
`timescale 1ns/10ps
module ccint_assert_chk #(
    parameter DEBOUNCE_CYC = 20,
    parameter STEP_CYC = 4
) (
    input wire CLK_I,
    input wire RST_I,
    input wire SUPPLY_FAULT_I,
    input wire CS_N_I,
    input wire CMD_STROBE_I,
    input wire [7:0] CMD_BYTE_I,
    input wire INT_N_O,
    input wire [1:0] CARD_SUPPLY_LEVEL_O,
    input wire CONVERTER_EN_O,
    input wire CARD_PRESENT_O,
    input wire PEND_OVERLOAD_O,
    input wire CARD_RESET_LOW_O,
    input wire CARD_CLOCK_LOW_O
);
    // command this chip takes; zero write is the only overload clear
    wire vld = CMD_STROBE_I && !CS_N_I && (!CMD_BYTE_I[7] || CMD_BYTE_I[7:5] == 3'b101);
    wire zw = vld && CMD_BYTE_I[1:0] == 2'b00;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ack with no fresh event while the answer is pending
    sequence s_ack;
        vld && !(PEND_OVERLOAD_O && CMD_BYTE_I[1:0] != 2'b00) && $stable(CARD_PRESENT_O) && !$rose(SUPPLY_FAULT_I)
        ##1 $stable(CARD_PRESENT_O) && !$rose(SUPPLY_FAULT_I) ##1 $stable(CARD_PRESENT_O);
    endsequence
    AST_RESET_HIGH: assert property ($fell(RST_I) |-> INT_N_O) else $error("int low after reset");
    AST_CARD_EVENT: assert property ($changed(CARD_PRESENT_O) |-> ##[0:2] !INT_N_O) else $error("no card int");
    AST_FAULT_INT: assert property ($rose(SUPPLY_FAULT_I) |-> ##[1:2] !INT_N_O) else $error("no fault int");
    AST_FAULT_OFF: assert property ($rose(SUPPLY_FAULT_I) |-> ##[1:3] !CONVERTER_EN_O) else $error("conv on");
    AST_INT_HOLDS: assert property (!INT_N_O && !vld && !$past(vld) |=> !INT_N_O) else $error("int rose");
    AST_OVL_HOLDS: assert property (PEND_OVERLOAD_O && !zw && !$past(zw) |=> PEND_OVERLOAD_O) else $error("ovl lost");
    AST_ACK_RELEASE: assert property (s_ack |-> INT_N_O) else $error("int not released");
    AST_DEACT_ORDER: assert property ($rose(CARD_CLOCK_LOW_O) |-> $past(CARD_RESET_LOW_O, STEP_CYC)) else $error("order");
endmodule // ccint_assert_chk
bind ccint_top ccint_assert_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .STEP_CYC(STEP_CYC)) u_chk (.*);

// ===== testbench/ccint_host_model.sv
`timescale 1ns/10ps
// host side: one byte per strobe; idle byte toggles so stale data never looks valid
module ccint_host_model (
    input wire clk_i,
    input wire go_i,
    input wire cs_n_i,
    input wire [7:0] byte_i,
    output reg cs_n_o = 1'b1,
    output reg strobe_o = 1'b0,
    output reg [7:0] cmd_o = 8'h00
);
    // select and address travel with the strobe
    always @(posedge clk_i) begin
        strobe_o <= go_i;
        cs_n_o <= go_i ? cs_n_i : 1'b1;
        cmd_o <= go_i ? byte_i : ~cmd_o;
    end
endmodule // ccint_host_model

// ===== testbench/test_ccint_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked = checked + 1; if ((a) !== (b)) begin err_total = err_total + 1; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_ccint_top;
    reg CLK_I = 1'b0;
    reg RST_I = 1'b1;
    reg pres = 1'b0;
    reg flt = 1'b0;
    reg go = 1'b0;
    reg go_cs_n = 1'b1;
    reg [7:0] go_byte = 8'h00;
    wire cs_n, stb, int_n, conv, busy, pi_o, po_o, rl;
    wire [7:0] cmd;
    wire [1:0] lvl;
    integer err_total = 0, checked = 0, cyc = 0, pi = 0, po = 0, a, s;
    always #5 CLK_I = ~CLK_I;
    ccint_host_model host (.clk_i(CLK_I), .go_i(go), .cs_n_i(go_cs_n), .byte_i(go_byte),
        .cs_n_o(cs_n), .strobe_o(stb), .cmd_o(cmd));
    // short counts keep the run brief
    ccint_top #(.DEBOUNCE_CYC(20), .STEP_CYC(4)) dut (.CLK_I(CLK_I), .RST_I(RST_I),
        .CARD_PRESENCE_IN_I(pres), .SUPPLY_FAULT_I(flt), .CS_N_I(cs_n), .CMD_STROBE_I(stb),
        .CMD_BYTE_I(cmd), .INT_N_O(int_n), .CARD_SUPPLY_LEVEL_O(lvl), .CONVERTER_EN_O(conv),
        .CARD_PRESENT_O(), .PEND_INSERT_O(pi_o), .PEND_OVERLOAD_O(po_o), .CARD_RESET_LOW_O(rl),
        .CARD_CLOCK_LOW_O(), .AUX_CONTACT_A_LOW_O(), .AUX_CONTACT_B_LOW_O(),
        .CARD_DATA_LINE_LOW_O(), .DEACT_BUSY_O(busy));
    task tally_and_finish;
        $display("counts checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // one write via the host; model applies the clearing table
    task wr(input reg csn, input reg [2:0] ad, input reg [1:0] st);
        @(posedge CLK_I) go <= 1'b1;
        go_cs_n <= csn;
        go_byte <= {ad, 3'b000, st};
        @(posedge CLK_I) go <= 1'b0;
        repeat (4) @(posedge CLK_I);
        if (!csn && (ad < 4 || ad == 5)) begin
            pi = 0;
            if (st == 2'b00) po = 0;
        end
    endtask
    // compare pin and status flags with the model, sampled mid-cycle
    task see(input integer w);
        repeat (w) @(posedge CLK_I);
        @(negedge CLK_I);
        `CHK(int_n, !(pi || po))
        `CHK(po_o, po[0])
        `CHK(pi_o, pi[0])
    endtask
    // hang guard, well beyond the scripted length
    always @(posedge CLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            tally_and_finish;
        end
    end
    initial begin
        s = $urandom(32'h6a0d1f9c);
        repeat (8) @(posedge CLK_I);
        RST_I <= 1'b0;
        see(2);
        for (a = 0; a < 8; a = a + 1) begin
            @(posedge CLK_I) flt <= 1'b1;
            po = 1;
            see(3);
            s = $urandom_range(3, 1);
            wr(1'b0, 3'd0, s[1:0]);
            flt <= 1'b0;
            see(0);
            wr(1'b1, a[2:0], 2'b00);
            see(0);
            wr(1'b0, a[2:0], 2'b00);
            see(0);
        end
        wr(1'b0, 3'd1, 2'b00);
        see(0);
        $display("test addresses done");
        @(posedge CLK_I) pres <= 1'b1;
        pi = 1;
        see(30);
        s = $urandom_range(3, 1);
        wr(1'b0, 3'd5, s[1:0]);
        see(0);
        `CHK(lvl, s[1:0])
        @(posedge CLK_I) pres <= 1'b0;
        pi = 1;
        see(28);
        `CHK(rl, 1'b1)
        @(posedge CLK_I) pres <= 1'b1;
        see(30);
        wr(1'b0, 3'd3, 2'b00);
        see(0);
        `CHK(busy, 1'b0)
        `CHK(conv, 1'b0)
        $display("test card events done");
        tally_and_finish;
    end
endmodule // test_ccint_top
